/* File: src/lia_dev_end.sv */
// Device end of the legacy interrupt aggregator in the host bridge.
// Assumes downstream port messages arrive as same-clock pulses from link logic.
//
// Rules of the document
// RULE_01: Legacy requests use pins or mode 111b.
// RULE_02: Exactly one legacy controller exists system-wide.
// RULE_03: Downstream devices request via assert/deassert messages.
// RULE_04: Forward interrupt acknowledge to the south bridge.
// RULE_05: One tracking bit per line per port.
// RULE_06: OR ports per line; send assert on rise.
// RULE_07: All bits clear sends that line's deassert.
// RULE_08: Switches present at most four lines at once.
// RULE_09: Never drive or watch processor interrupt pins.
// RULE_10: Deliver to absent processors; still complete.
// RULE_11: Correct single-bit, log double-bit data errors. This code has no error correction or logging.
// RULE_12: Power event message sends power assert.
// RULE_13: Clearing power flag sends power deassert.
// RULE_14: Power assert possible after suspend-exit reset.
// RULE_15: Power messages wired-OR across all ports.
// RULE_16: South bridge warns before platform reset.
// RULE_17: Acknowledge reset warning at the earliest.
// RULE_18: No memory quiesce before platform reset.
// RULE_19: No inband path for stop-clock signal.
// RULE_20: Power assert while enabled flag set; W1C.
// RULE_21: Hot-plug output by enable priority order.
`default_nettype none
module lia_dev_end
  import lia_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Downstream port legacy messages
  input wire logic [NUM_PORTS-1:0] port_int_raise_i,
  input wire logic [NUM_PORTS-1:0] port_int_drop_i,
  input wire logic [LINE_W-1:0] port_line_i [NUM_PORTS],
  // Downstream power events and root status
  input wire logic [NUM_PORTS-1:0] port_pme_i,
  input wire logic [NUM_PORTS-1:0] pme_enable_i,
  input wire logic [NUM_PORTS-1:0] pme_clear_i,
  output logic [NUM_PORTS-1:0] power_event_flag_o,
  // Hot-plug event and its enables
  input wire logic [NUM_PORTS-1:0] hp_event_i,
  input wire logic [NUM_PORTS-1:0] hp_clear_i,
  input wire logic hotplug_event_msg_enable_i,
  input wire logic hotplug_irq_enable_i,
  input wire logic message_irq_enable_i,
  input wire logic legacy_wire_disable_i,
  output logic msi_req_o,
  // Processor interrupt acknowledge
  input wire logic intack_req_i,
  output logic intack_busy_o,
  output logic intack_done_o,
  output logic [VEC_W-1:0] intack_vector_o,
  // Reset warning handshake seen
  output logic rst_warn_seen_o,
  // Link to south bridge
  lia_link_if.dev link
);
  import lia_pkg::*;

  // ---------------------------------------------------------------
  // Legacy line tracking
  // ---------------------------------------------------------------
  logic [NUM_LINES-1:0] line_pend, line_level, line_sent;
  logic [NUM_PORTS-1:0] line_set [NUM_LINES];
  logic [NUM_PORTS-1:0] line_clr [NUM_LINES];
  logic hp_pend, hp_level, hp_sent, pm_pend, pm_level, pm_sent;
  logic [NUM_PORTS-1:0] hp_intx_bits, hp_set;
  lia_hp_t hp_mode;

  // RULE_21 priority select
  assign hp_mode = hotplug_event_msg_enable_i ? LIA_HP_GPE :
                   !hotplug_irq_enable_i ? LIA_HP_NONE :
                   message_irq_enable_i ? LIA_HP_MSI :
                   legacy_wire_disable_i ? LIA_HP_NONE : LIA_HP_INTX;
  // Event pulse, not the held hot-plug bit: a held set would beat every clear
  assign hp_intx_bits = (hp_mode == LIA_HP_INTX) ? hp_event_i : PORTS_CLEAR;

  genvar g, p;
  generate
    for (g = 0; g < NUM_LINES; g++) begin : g_line
      for (p = 0; p < NUM_PORTS; p++) begin : g_port
        // RULE_05 set and clear
        assign line_set[g][p] = port_int_raise_i[p] && (port_line_i[p] == LINE_W'(g));
        assign line_clr[g][p] = port_int_drop_i[p] && (port_line_i[p] == LINE_W'(g));
      end
      // Hot-plug legacy output rides on line A together with port requests;
      // it shares the port's line A bit, so a hot-plug clear also drops it
      // RULE_06 OR per line
      lia_wire_track u_track (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .set_i(line_set[g] | ((g == 0) ? hp_intx_bits : PORTS_CLEAR)),
        .clr_i(line_clr[g] | ((g == 0) ? hp_clear_i : PORTS_CLEAR)),
        .en_i({NUM_PORTS{1'b1}}),
        .sent_i(line_sent[g]),
        .bits_o(),
        .wire_o(),
        .pend_o(line_pend[g]),
        .pend_level_o(line_level[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Hot-plug and power events
  // ---------------------------------------------------------------
  assign hp_set = hp_event_i;
  lia_wire_track u_hp (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .set_i(hp_set),
    .clr_i(hp_clear_i),
    .en_i((hp_mode == LIA_HP_GPE) ? {NUM_PORTS{1'b1}} : PORTS_CLEAR),
    .sent_i(hp_sent),
    .bits_o(),
    .wire_o(),
    .pend_o(hp_pend),
    .pend_level_o(hp_level)
  );

  // One MSI request per new hot-plug event while selected
  assign msi_req_o = (hp_mode == LIA_HP_MSI) && (|hp_event_i);

  // RULE_12 flag set by event
  // RULE_20 enabled flags; write-1 clears, set wins
  // RULE_15 wired-OR over ports
  lia_wire_track u_pm (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .set_i(port_pme_i),
    .clr_i(pme_clear_i),
    .en_i(pme_enable_i),
    .sent_i(pm_sent),
    .bits_o(power_event_flag_o),
    .wire_o(),
    .pend_o(pm_pend),
    .pend_level_o(pm_level)
  );
  // RULE_14 after reset the flags start clear, so a fresh event raises again

  // ---------------------------------------------------------------
  // Reset warning and interrupt acknowledge
  // ---------------------------------------------------------------
  logic warn_pend_ff, warn_seen_ff, ack_busy_ff, ack_req_ff, ack_done_ff;
  logic [VEC_W-1:0] vec_ff;
  logic warn_sent, ack_sent;
  wire got_warn = link.dn_valid && (link.dn_msg == LIA_MSG_RST_WARN);
  wire got_vec = link.dn_valid && (link.dn_msg == LIA_MSG_VECTOR) && ack_busy_ff;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      warn_pend_ff <= 1'b0;
      warn_seen_ff <= 1'b0;
      ack_busy_ff <= 1'b0;
      ack_req_ff <= 1'b0;
      ack_done_ff <= 1'b0;
      vec_ff <= VEC_CLEAR;
    end else begin
      // RULE_17 queue acknowledge
      warn_pend_ff <= got_warn | (warn_pend_ff & ~warn_sent);
      warn_seen_ff <= warn_seen_ff | got_warn;
      // RULE_04 forward acknowledge
      if (intack_req_i && !ack_busy_ff) begin
        ack_busy_ff <= 1'b1;
        ack_req_ff <= 1'b1;
      end else if (got_vec) begin
        ack_busy_ff <= 1'b0;
      end
      if (ack_sent) begin
        ack_req_ff <= 1'b0;
      end
      ack_done_ff <= got_vec;
      if (got_vec) begin
        vec_ff <= link.dn_vector;
      end
    end
  end
  // RULE_18 no memory quiesce; RULE_19 no stop-clock path; RULE_09 no pins
  // RULE_10 messages complete without any target lookup
  // RULE_11 no stored payload here needs error protection

  // ---------------------------------------------------------------
  // Upstream message arbiter: reset ack first, then acknowledge, power,
  // hot-plug, lines A to D. Fixed order is fine since each source holds.
  // ---------------------------------------------------------------
  logic [LINE_W-1:0] pick_line;
  logic any_line;
  always_comb begin
    pick_line = '0;
    any_line = 1'b0;
    for (int i = NUM_LINES - 1; i >= 0; i--) begin
      if (line_pend[i]) begin
        pick_line = LINE_W'(i);
        any_line = 1'b1;
      end
    end
  end

  wire sel_warn = warn_pend_ff;
  wire sel_ack = !sel_warn && ack_req_ff;
  wire sel_pm = !sel_warn && !ack_req_ff && pm_pend;
  wire sel_hp = !sel_warn && !ack_req_ff && !pm_pend && hp_pend;
  wire sel_line = !sel_warn && !ack_req_ff && !pm_pend && !hp_pend && any_line;
  wire fire = link.up_valid && link.up_ready;

  assign warn_sent = fire && sel_warn;
  assign ack_sent = fire && sel_ack;
  // RULE_13 drop when flags clear
  assign pm_sent = fire && sel_pm;
  assign hp_sent = fire && sel_hp;
  // RULE_07 deassert on all clear
  assign line_sent = (fire && sel_line) ? (NUM_LINES'(1) << pick_line) : LINES_CLEAR;

  assign link.up_valid = sel_warn | sel_ack | sel_pm | sel_hp | sel_line;
  assign link.up_line = sel_line ? pick_line : '0;
  assign link.up_msg = sel_warn ? LIA_MSG_RST_ACK :
                       sel_ack ? LIA_MSG_INTACK :
                       sel_pm ? (pm_level ? LIA_MSG_GPE_RAISE : LIA_MSG_GPE_DROP) :
                       sel_hp ? (hp_level ? LIA_MSG_HPG_RAISE : LIA_MSG_HPG_DROP) :
                       sel_line ? (line_level[pick_line] ? LIA_MSG_INT_RAISE
                                                        : LIA_MSG_INT_DROP) :
                       LIA_MSG_NONE;

  assign intack_busy_o = ack_busy_ff;
  assign intack_done_o = ack_done_ff;
  assign intack_vector_o = vec_ff;
  assign rst_warn_seen_o = warn_seen_ff;
endmodule
`default_nettype wire

/* File: src/lia_link_if.sv */
// Interface joining the device end and the south bridge end.
// Assumes both ends run on the same clock; messages are one-cycle valid/ready beats.
`default_nettype none
interface lia_link_if;
  import lia_pkg::*;
  // Device to south bridge
  logic up_valid;
  logic up_ready;
  lia_msg_t up_msg;
  logic [LINE_W-1:0] up_line;
  // South bridge to device
  logic dn_valid;
  lia_msg_t dn_msg;
  logic [VEC_W-1:0] dn_vector;

  modport dev (output up_valid, output up_msg, output up_line, input up_ready,
               input dn_valid, input dn_msg, input dn_vector);
  modport sb (input up_valid, input up_msg, input up_line, output up_ready,
              output dn_valid, output dn_msg, output dn_vector);
endinterface
`default_nettype wire

/* File: src/lia_pkg.sv */
// Package for the legacy interrupt aggregator: message codes, widths, reset values.
// Assumes a single core clock domain shared by both ends.
`default_nettype none
package lia_pkg;
  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_PORTS = 4;
  localparam int NUM_LINES = 4;
  localparam int MSG_W = 4;
  localparam int PIDX_W = 2;
  localparam int LINE_W = 2;
  localparam int VEC_W = 8;
  localparam logic [NUM_LINES-1:0] LINES_CLEAR = 4'h0;
  localparam logic [NUM_PORTS-1:0] PORTS_CLEAR = 4'h0;
  localparam logic [VEC_W-1:0] VEC_CLEAR = 8'h00;
  localparam logic [2:0] EXT_VECTOR_MODE = 3'b111;

  // ---------------------------------------------------------------
  // Messages on the south bridge link
  // ---------------------------------------------------------------
  typedef enum logic [MSG_W-1:0] {
    LIA_MSG_NONE      = 4'h0,
    LIA_MSG_INT_RAISE = 4'h1,
    LIA_MSG_INT_DROP  = 4'h2,
    LIA_MSG_GPE_RAISE = 4'h3,
    LIA_MSG_GPE_DROP  = 4'h4,
    LIA_MSG_HPG_RAISE = 4'h5,
    LIA_MSG_HPG_DROP  = 4'h6,
    LIA_MSG_INTACK    = 4'h7,
    LIA_MSG_RST_WARN  = 4'h8,
    LIA_MSG_RST_ACK   = 4'h9,
    LIA_MSG_VECTOR    = 4'hA
  } lia_msg_t;

  // Hot-plug output choice
  typedef enum logic [1:0] {
    LIA_HP_NONE = 2'b00,
    LIA_HP_GPE  = 2'b01,
    LIA_HP_MSI  = 2'b10,
    LIA_HP_INTX = 2'b11
  } lia_hp_t;
endpackage
`default_nettype wire

/* File: src/lia_sb_end.sv */
// South bridge end: tracks the four virtual wires and power/hot-plug levels,
// answers acknowledges with a vector and issues the reset warning.
// Assumes the device end shares its clock.
`default_nettype none
module lia_sb_end
  import lia_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // User side
  input wire logic sink_ready_i,
  input wire logic [VEC_W-1:0] vector_i,
  input wire logic rst_warn_req_i,
  output logic [NUM_LINES-1:0] virt_wire_o,
  output logic power_gpe_o,
  output logic hotplug_gpe_o,
  output logic rst_warn_acked_o,
  output logic [2:0] delivery_mode_o,
  output logic platform_reset_n_o,
  // Link to device
  lia_link_if.sb link
);
  import lia_pkg::*;

  logic [NUM_LINES-1:0] wire_ff;
  logic pwr_ff, hpg_ff, acked_ff, warn_out_ff, vec_out_ff, warned_ff, prst_n_ff;
  logic [VEC_W-1:0] vec_ff;
  wire fire = link.up_valid && sink_ready_i;
  wire [NUM_LINES-1:0] line_bit = NUM_LINES'(1) << link.up_line;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wire_ff <= LINES_CLEAR;
      pwr_ff <= 1'b0;
      hpg_ff <= 1'b0;
      acked_ff <= 1'b0;
      warn_out_ff <= 1'b0;
      vec_out_ff <= 1'b0;
      warned_ff <= 1'b0;
      prst_n_ff <= 1'b1;
      vec_ff <= VEC_CLEAR;
    end else begin
      // RULE_16 warning goes out, reset only after its ack
      warn_out_ff <= rst_warn_req_i && !warned_ff;
      if (rst_warn_req_i && !warned_ff) begin
        warned_ff <= 1'b1;
      end
      vec_out_ff <= 1'b0;
      if (fire) begin
        unique case (link.up_msg)
          LIA_MSG_INT_RAISE: wire_ff <= wire_ff | line_bit;
          LIA_MSG_INT_DROP: wire_ff <= wire_ff & ~line_bit;
          LIA_MSG_GPE_RAISE: pwr_ff <= 1'b1;
          LIA_MSG_GPE_DROP: pwr_ff <= 1'b0;
          LIA_MSG_HPG_RAISE: hpg_ff <= 1'b1;
          LIA_MSG_HPG_DROP: hpg_ff <= 1'b0;
          // RULE_02 the single legacy controller supplies the vector
          LIA_MSG_INTACK: begin
            vec_out_ff <= 1'b1;
            vec_ff <= vector_i;
          end
          LIA_MSG_RST_ACK: begin
            acked_ff <= 1'b1;
            prst_n_ff <= 1'b0;
          end
          default: begin
          end
        endcase
      end
    end
  end

  assign link.up_ready = sink_ready_i;
  // Warning wins if it meets a vector in the same cycle: warning is one pulse per reset
  assign link.dn_valid = warn_out_ff | vec_out_ff;
  assign link.dn_msg = warn_out_ff ? LIA_MSG_RST_WARN :
                       vec_out_ff ? LIA_MSG_VECTOR : LIA_MSG_NONE;
  assign link.dn_vector = vec_ff;
  assign virt_wire_o = wire_ff;
  assign power_gpe_o = pwr_ff;
  assign hotplug_gpe_o = hpg_ff;
  assign rst_warn_acked_o = acked_ff;
  // RULE_01 legacy delivery uses the external vector mode
  assign delivery_mode_o = EXT_VECTOR_MODE;
  assign platform_reset_n_o = prst_n_ff;
endmodule
`default_nettype wire

/* File: src/lia_wire_track.sv */
// One virtual wire: OR of per-source tracking bits and a pending edge message.
// Assumes set/clear pulses come from logic on the same clock.
`default_nettype none
module lia_wire_track
  import lia_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Sources
  input wire logic [NUM_PORTS-1:0] set_i,
  input wire logic [NUM_PORTS-1:0] clr_i,
  input wire logic [NUM_PORTS-1:0] en_i,
  // Message handshake
  input wire logic sent_i,
  output logic [NUM_PORTS-1:0] bits_o,
  output logic wire_o,
  output logic pend_o,
  output logic pend_level_o
);
  logic [NUM_PORTS-1:0] bits_ff;
  logic sent_level_ff;
  wire [NUM_PORTS-1:0] nxt_bits = (bits_ff & ~clr_i) | set_i;
  wire cur_wire = |(bits_ff & en_i);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bits_ff <= PORTS_CLEAR;
      sent_level_ff <= 1'b0;
    end else begin
      // Set wins over a clear in the same cycle
      bits_ff <= nxt_bits;
      if (sent_i) begin
        sent_level_ff <= cur_wire;
      end
    end
  end

  // Pending whenever the last level sent differs from the OR; a pulse that
  // rises and falls before it is sent collapses to nothing, as level wires do
  assign bits_o = bits_ff;
  assign wire_o = cur_wire;
  assign pend_o = cur_wire != sent_level_ff;
  assign pend_level_o = cur_wire;
endmodule
`default_nettype wire

/* File: test/lia_props.sv */
// Concurrent checks on the link between the device end and the south bridge end.
// Assumes one clock; instantiated by the bench beside the link interface.
`default_nettype none
module lia_props (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Link signals
  input wire logic up_valid,
  input wire logic up_ready,
  input wire lia_pkg::lia_msg_t up_msg,
  input wire logic [lia_pkg::LINE_W-1:0] up_line,
  input wire logic dn_valid,
  input wire lia_pkg::lia_msg_t dn_msg,
  input wire logic [lia_pkg::VEC_W-1:0] dn_vector
);
  timeunit 1ns;
  timeprecision 1ns;
  import lia_pkg::*;
  // ----------------------------------------
  // Shadow of what the far end has been told
  // ----------------------------------------
  logic [NUM_LINES-1:0] wires_ff;
  logic gpe_ff;
  logic warned_ff;
  wire logic taken = up_valid && up_ready;
  wire logic [NUM_LINES-1:0] sel = 4'h1 << up_line;
  wire logic i_up = taken && up_msg == LIA_MSG_INT_RAISE;
  wire logic i_dn = taken && up_msg == LIA_MSG_INT_DROP;
  wire logic g_up = taken && up_msg == LIA_MSG_GPE_RAISE;
  wire logic g_dn = taken && up_msg == LIA_MSG_GPE_DROP;
  wire logic warn = dn_valid && dn_msg == LIA_MSG_RST_WARN;
  wire logic [NUM_LINES-1:0] nxt_wires = i_up ? (wires_ff | sel) :
                                         i_dn ? (wires_ff & ~sel) : wires_ff;
  wire logic nxt_gpe = g_up | (gpe_ff & ~g_dn);
  wire logic nxt_warned = warned_ff | warn;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wires_ff <= LINES_CLEAR;
      gpe_ff <= 1'b0;
      warned_ff <= 1'b0;
    end else begin
      wires_ff <= nxt_wires;
      gpe_ff <= nxt_gpe;
      warned_ff <= nxt_warned;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  chk_raise_fresh: assert property (i_up |-> !wires_ff[up_line])
    else $error("line raise sent while wire already high");
  chk_drop_after: assert property (i_dn |-> wires_ff[up_line])
    else $error("line drop sent while wire low");
  chk_gpe_fresh: assert property (g_up |-> !gpe_ff)
    else $error("power raise sent twice");
  chk_gpe_drop: assert property (g_dn |-> gpe_ff)
    else $error("power drop sent without raise");
  chk_valid_hold: assert property (up_valid && !up_ready |=>
    up_valid && $stable(up_msg) && $stable(up_line)) else $error("stalled message changed");
  chk_warn_ack: assert property (warn |-> ##[1:2] (up_valid && up_msg == LIA_MSG_RST_ACK))
    else $error("reset warning not acknowledged in time");
  chk_ack_warned: assert property (up_valid && up_msg == LIA_MSG_RST_ACK |->
    warned_ff || warn) else $error("acknowledge without warning");
  chk_intack_vec: assert property (taken && up_msg == LIA_MSG_INTACK |=>
    dn_valid && dn_msg == LIA_MSG_VECTOR) else $error("no vector after acknowledge");
  cover property (i_dn && up_line == 2'd3);
  cover property (up_valid && !up_ready);
  cover property (dn_valid && dn_msg == LIA_MSG_VECTOR && dn_vector != VEC_CLEAR);
endmodule
`default_nettype wire

/* File: test/tb_legacy_intx_aggregator.sv */
// Self-checking bench: both ends joined by the link interface.
// Assumes the package and both design ends are compiled first.
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb_legacy_intx_aggregator;
  timeunit 1ns;
  timeprecision 1ns;
  import lia_pkg::*;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [NUM_PORTS-1:0] int_raise, int_drop, pme, pme_en, pme_clr, hp_ev, hp_clr, pe_flag;
  logic [LINE_W-1:0] port_line [NUM_PORTS];
  logic hp_gpe_en, hp_irq_en, msi_en, lw_dis, intack_req, sink_ready, rst_warn_req;
  logic msi_req, ia_busy, ia_done, warn_seen, pgpe, hgpe, warn_acked, plat_rst_n;
  logic [VEC_W-1:0] vec_in, ia_vec;
  logic [NUM_LINES-1:0] vwire;
  logic [2:0] dmode;
  int err_total = 0;
  int n_compared = 0;
  // Rows: raise, port, line, expected virtual wires
  // each port holds one line at most
  logic [8:0] rows [10] = '{9'h101, 9'h141, 9'h001, 9'h040, 9'h1B8,
                            9'h1DA, 9'h0B2, 9'h0D0, 9'h164, 9'h060};
  // Modes: hp gpe, hp irq, msi, legacy off, then expected gpe, msi, line A
  logic [6:0] modes [5] = '{7'h44, 7'h32, 7'h21, 7'h28, 7'h00};
  lia_link_if link ();
  lia_dev_end i_lia_dev_end (
    .clk_i(clk_i), .resetn_i(resetn_i),
    .port_int_raise_i(int_raise), .port_int_drop_i(int_drop), .port_line_i(port_line),
    .port_pme_i(pme), .pme_enable_i(pme_en), .pme_clear_i(pme_clr),
    .power_event_flag_o(pe_flag), .hp_event_i(hp_ev), .hp_clear_i(hp_clr),
    .hotplug_event_msg_enable_i(hp_gpe_en), .hotplug_irq_enable_i(hp_irq_en),
    .message_irq_enable_i(msi_en), .legacy_wire_disable_i(lw_dis), .msi_req_o(msi_req),
    .intack_req_i(intack_req), .intack_busy_o(ia_busy), .intack_done_o(ia_done),
    .intack_vector_o(ia_vec), .rst_warn_seen_o(warn_seen), .link(link));
  lia_sb_end i_lia_sb_end (
    .clk_i(clk_i), .resetn_i(resetn_i), .sink_ready_i(sink_ready), .vector_i(vec_in),
    .rst_warn_req_i(rst_warn_req), .virt_wire_o(vwire), .power_gpe_o(pgpe),
    .hotplug_gpe_o(hgpe), .rst_warn_acked_o(warn_acked), .delivery_mode_o(dmode),
    .platform_reset_n_o(plat_rst_n), .link(link));
  lia_props i_lia_props (
    .clk_i(clk_i), .resetn_i(resetn_i), .up_valid(link.up_valid), .up_ready(link.up_ready),
    .up_msg(link.up_msg), .up_line(link.up_line), .dn_valid(link.dn_valid),
    .dn_msg(link.dn_msg), .dn_vector(link.dn_vector));
  always #5 clk_i = ~clk_i;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic line_msg(input logic up, input int p, input logic [1:0] l);
    port_line[p] = l;
    if (up) int_raise[p] = 1'b1;
    else int_drop[p] = 1'b1;
    tick(1);
    int_raise = PORTS_CLEAR;
    int_drop = PORTS_CLEAR;
    tick(4);
  endtask
  task automatic pulse(ref logic [NUM_PORTS-1:0] s, input logic [NUM_PORTS-1:0] v);
    s = v;
    tick(1);
    s = PORTS_CLEAR;
    tick(4);
  endtask
  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  // The tests need about 185 cycles; the watchdog allows 3000, about sixteen times that
  initial begin
    #30000;
    err_total++;
    results();
  end
  initial begin
    {int_raise, int_drop, pme, pme_clr, hp_ev, hp_clr} = '0;
    port_line = '{2'd0, 2'd0, 2'd0, 2'd0};
    {hp_gpe_en, hp_irq_en, msi_en, lw_dis, intack_req, rst_warn_req} = '0;
    pme_en = 4'hD;
    sink_ready = 1'b1;
    vec_in = 8'hC3;
    tick(4);
    resetn_i = 1'b1;
    tick(1);
    `CHK({vwire, pgpe, plat_rst_n, pe_flag}, 10'h010)
    `CHK(dmode, EXT_VECTOR_MODE)
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      line_msg(rows[i][8], int'(rows[i][7:6]), rows[i][5:4]);
      `CHK(vwire, rows[i][3:0])
    end
    $display("test rows done");
    sink_ready = 1'b0;
    line_msg(1'b1, 0, 2'd0);
    line_msg(1'b1, 1, 2'd1);
    line_msg(1'b0, 1, 2'd1);
    `CHK(vwire, LINES_CLEAR)
    sink_ready = 1'b1;
    tick(4);
    `CHK(vwire, 4'h1)
    line_msg(1'b0, 0, 2'd0);
    `CHK(vwire, LINES_CLEAR)
    $display("test stall done");
    pulse(pme, 4'h4);
    `CHK({pe_flag, pgpe}, 5'h09)
    pulse(pme, 4'h2);
    pulse(pme_clr, 4'h4);
    `CHK({pe_flag, pgpe}, 5'h04)
    pme_en = 4'hF;
    tick(4);
    `CHK(pgpe, 1'b1)
    pulse(pme, 4'h1);
    pulse(pme_clr, 4'h2);
    `CHK(pgpe, 1'b1)
    pulse(pme_clr, 4'h1);
    `CHK({pe_flag, pgpe}, 5'h00)
    $display("test power done");
    for (int i = 0; i < 5; i++) begin
      {hp_gpe_en, hp_irq_en, msi_en, lw_dis} = modes[i][6:3];
      tick(1);
      hp_ev = 4'h8;
      #2;
      `CHK(msi_req, modes[i][1])
      tick(1);
      hp_ev = PORTS_CLEAR;
      tick(4);
      `CHK({hgpe, vwire[0]}, {modes[i][2], modes[i][0]})
      pulse(hp_clr, 4'h8);
      `CHK({hgpe, vwire[0]}, 2'b00)
    end
    $display("test hotplug done");
    intack_req = 1'b1;
    tick(1);
    intack_req = 1'b0;
    `CHK(ia_busy, 1'b1)
    for (int k = 0; k < 10 && ia_done !== 1'b1; k++) tick(1);
    `CHK({ia_done, ia_vec}, 9'h1C3)
    tick(1);
    `CHK(ia_busy, 1'b0)
    $display("test intack done");
    rst_warn_req = 1'b1;
    tick(2);
    `CHK({warn_seen, plat_rst_n}, 2'b11)
    for (int k = 0; k < 10 && warn_acked !== 1'b1; k++) tick(1);
    `CHK({warn_acked, warn_seen, plat_rst_n}, 3'b110)
    rst_warn_req = 1'b0;
    resetn_i = 1'b0;
    tick(2);
    resetn_i = 1'b1;
    tick(1);
    `CHK({warn_acked, plat_rst_n, pgpe}, 3'b010)
    pulse(pme, 4'h1);
    `CHK(pgpe, 1'b1)
    $display("test reset warning done");
    results();
  end
endmodule
`default_nettype wire
